// ### hw/sbp_pkg.sv
// Package of constants and types for the parallel slave port
package sbp_pkg;
    localparam int          SBP_DW              = 8;
    localparam int          SBP_AW              = 4;
    // Register indices on the internal register port
    localparam logic [3:0]  SBP_A_CONTROL       = 4'h0;
    localparam logic [3:0]  SBP_A_DATA_PINS     = 4'h1;
    localparam logic [3:0]  SBP_A_DATA_LATCH    = 4'h2;
    localparam logic [3:0]  SBP_A_DATA_DIR      = 4'h3;
    localparam logic [3:0]  SBP_A_CTL_PINS      = 4'h4;
    localparam logic [3:0]  SBP_A_CTL_LATCH     = 4'h5;
    localparam logic [3:0]  SBP_A_CTL_DIR       = 4'h6;
    localparam logic [3:0]  SBP_A_IRQ_FLAGS     = 4'h7;
    localparam logic [3:0]  SBP_A_IRQ_ENABLES   = 4'h8;
    localparam logic [3:0]  SBP_A_IRQ_PRIORITY  = 4'h9;
    localparam logic [3:0]  SBP_A_MODE          = 4'ha;
    // Control register fields, then the interrupt bit and the mode register's internal-only bit
    localparam int          SBP_B_INPUT_FULL    = 7;
    localparam int          SBP_B_OUTPUT_FULL   = 6;
    localparam int          SBP_B_OVERRUN       = 5;
    localparam int          SBP_B_SELECT        = 4;
    localparam int          SBP_B_IRQ           = 7;
    localparam int          SBP_B_INTERNAL_ONLY = 0;
    // Control-port pin positions
    localparam int          SBP_P_READ          = 0;
    localparam int          SBP_P_WRITE         = 1;
    localparam int          SBP_P_CS            = 2;
    // Reset values, byte constants and control masks
    localparam logic [7:0]  SBP_RST_CONTROL     = 8'h00;
    localparam logic [7:0]  SBP_RST_DIR         = 8'hff;
    localparam logic [7:0]  SBP_RST_LATCH       = 8'h00;
    localparam logic [7:0]  SBP_RST_IRQ_FLAGS   = 8'h00;
    localparam logic [7:0]  SBP_RST_IRQ_EN      = 8'h00;
    localparam logic [7:0]  SBP_RST_IRQ_PRIO    = 8'hff;
    localparam logic [7:0]  SBP_ZERO            = 8'h00;
    localparam logic [7:0]  SBP_ONES            = 8'hff;
    localparam logic [7:0]  SBP_CTL_RW_MASK     = 8'h30;
    localparam logic [7:0]  SBP_CTL_RD_MASK     = 8'hf0;

    typedef enum logic [1:0] {
        SBP_IDLE  = 2'b00,
        SBP_WRITE = 2'b01,
        SBP_READ  = 2'b10
    } sbp_access_t;
endpackage

// ### hw/sbp_strobe_if.sv
// Interface carrying synchronised strobes and access events
`timescale 1ns/1ps
interface sbp_strobe_if;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        write_evt;
    logic        read_evt;
    modport sync (output cs_n, output rd_n, output wr_n);
    modport detect (input cs_n, input rd_n, input wr_n, output write_evt, output read_evt);
    modport core (input write_evt, input read_evt);
endinterface

// ### hw/sbp_sync.sv
// Three-stage synchroniser for the external strobes, two-stage for the data pins
`timescale 1ns/1ps
module sbp_sync
    import sbp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               read_strobe_n,
    input  wire logic               write_strobe_n,
    input  wire logic               chip_select_n,
    input  wire logic [SBP_DW-1:0]  data_in,
    output      logic [SBP_DW-1:0]  data_sync,
    sbp_strobe_if.sync              sif
);
    typedef struct packed {
        logic [2:0]        s1;
        logic [2:0]        s2;
        logic [2:0]        s3;
        logic [2:0]        stable;
        logic [SBP_DW-1:0] d1;
        logic [SBP_DW-1:0] d2;
    } sbp_sync_t;

    sbp_sync_t st_ff;
    sbp_sync_t nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = {chip_select_n, write_strobe_n, read_strobe_n};
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // A change counts only when the second and third stages agree
        for (int i = 0; i < 3; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.stable[i] = st_ff.s3[i];
            end
        end
        nxt_st.d1 = data_in;
        nxt_st.d2 = st_ff.d1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7, stable: 3'h7,
                       d1: SBP_ZERO, d2: SBP_ZERO};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sif.rd_n  = st_ff.stable[SBP_P_READ];
    assign sif.wr_n  = st_ff.stable[SBP_P_WRITE];
    assign sif.cs_n  = st_ff.stable[SBP_P_CS];
    assign data_sync = st_ff.d2;
endmodule // sbp_sync

// ### hw/sbp_detect.sv
// First-detection of external read and write accesses
`timescale 1ns/1ps
module sbp_detect
    import sbp_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      reset_n,
    input  wire logic      enable,
    sbp_strobe_if.detect   sif
);
    typedef struct packed {
        sbp_access_t state;
        logic        wr_evt;
        logic        rd_evt;
    } sbp_det_t;

    sbp_det_t st_ff;
    sbp_det_t nxt_st;
    logic     wr_act;
    logic     rd_act;

    always_comb begin
        wr_act = !sif.cs_n && !sif.wr_n;
        rd_act = !sif.cs_n && !sif.rd_n;
        nxt_st        = st_ff;
        nxt_st.wr_evt = 1'b0;
        nxt_st.rd_evt = 1'b0;
        case (st_ff.state)
            SBP_IDLE: begin
                if (enable && wr_act) begin
                    nxt_st.state  = SBP_WRITE;
                    nxt_st.wr_evt = 1'b1; // [R06]
                end else if (enable && rd_act) begin
                    nxt_st.state  = SBP_READ;
                    nxt_st.rd_evt = 1'b1; // [R07]
                end
            end
            // One event per access: wait for the strobe pair to release
            SBP_WRITE: begin
                if (!wr_act) begin
                    nxt_st.state = SBP_IDLE;
                end
            end
            SBP_READ: begin
                if (!rd_act) begin
                    nxt_st.state = SBP_IDLE;
                end
            end
            default: begin
                nxt_st.state = SBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{state: SBP_IDLE, wr_evt: 1'b0, rd_evt: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sif.write_evt = st_ff.wr_evt;
    assign sif.read_evt  = st_ff.rd_evt;
endmodule // sbp_detect

// ### hw/sbp_top.sv
// Parallel slave port top: registers, pin muxing, flags and interrupt
`timescale 1ns/1ps
// Functional notes
// R01: Mode select turns the eight data pins into an external byte port.
// R02: Mode select is control bit 4; one is slave port, zero general I/O.
// R03: In slave mode three control pins are read, write and chip select inputs.
// R04: Software sets the three low control-port direction bits to inputs first.
// R05: Software sets analog pin configuration so strobe pins are digital.
// R06: Write taken on first detection of chip select and write strobe low.
// R07: Read taken on first detection of chip select and read strobe low.
// R08: External processor reads or writes the data latch asynchronously as one byte.
// R09: Input-full bit 7, read-only, set by external write, cleared by CPU read.
// R10: Output-full bit 6, read-only, set by CPU write, cleared by external read.
// R11: Overrun bit 5 set on write over unread input; software writes zero.
// R12: Control bits 3 to 0 read as zero.
// R13: Slave port only works in internal-program-memory-only mode.
// R14: Irq flag set per external access; enabled request at selected priority.
module sbp_top
    import sbp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic [SBP_AW-1:0]  reg_addr,
    input  wire logic [SBP_DW-1:0]  reg_wdata,
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    output      logic [SBP_DW-1:0]  reg_rdata,
    input  wire logic [SBP_DW-1:0]  data_pins_in,
    output      logic [SBP_DW-1:0]  data_pins_out,
    output      logic [SBP_DW-1:0]  data_pins_oe_n,
    input  wire logic [SBP_DW-1:0]  ctl_pins_in,
    output      logic [SBP_DW-1:0]  ctl_pins_out,
    output      logic [SBP_DW-1:0]  ctl_pins_oe_n,
    output      logic               irq_high,
    output      logic               irq_low
);
    typedef struct packed {
        logic [SBP_DW-1:0] control;
        logic [SBP_DW-1:0] data_latch;
        logic [SBP_DW-1:0] data_dir;
        logic [SBP_DW-1:0] in_byte;
        logic [SBP_DW-1:0] ctl_latch;
        logic [SBP_DW-1:0] ctl_dir;
        logic [SBP_DW-1:0] irq_flags;
        logic [SBP_DW-1:0] irq_en;
        logic [SBP_DW-1:0] irq_prio;
        logic [SBP_DW-1:0] mode;
        logic [SBP_DW-1:0] rdata;
        logic [SBP_DW-1:0] d_out;
        logic [SBP_DW-1:0] d_oe_n;
        logic [SBP_DW-1:0] c_out;
        logic [SBP_DW-1:0] c_oe_n;
        logic              irq_h;
        logic              irq_l;
    } sbp_top_t;

    sbp_top_t          st_ff;
    sbp_top_t          nxt_st;
    sbp_strobe_if      sif ();
    logic [SBP_DW-1:0] data_sync;
    logic              slave_on;
    logic              ext_wr;
    logic              ext_rd;
    logic              cpu_wr_data;
    logic              cpu_rd_data;
    logic [SBP_DW-1:0] flags_cur;
    logic              irq_req;

    // Decoded register hit, used for both read and write paths
    function automatic logic hit(input logic [SBP_AW-1:0] a, input logic [3:0] idx);
        return a == idx;
    endfunction

    // Slave mode needs the select bit and internal-only program memory mode
    assign slave_on = st_ff.control[SBP_B_SELECT]
                      && st_ff.mode[SBP_B_INTERNAL_ONLY]; // [R01] [R02] [R13]

    sbp_sync u_sync (
        .clk            (clk),
        .reset_n        (reset_n),
        .read_strobe_n  (ctl_pins_in[SBP_P_READ]),
        .write_strobe_n (ctl_pins_in[SBP_P_WRITE]),
        .chip_select_n  (ctl_pins_in[SBP_P_CS]),
        .data_in        (data_pins_in),
        .data_sync      (data_sync),
        .sif            (sif.sync)
    ); // [R03]

    sbp_detect u_detect (
        .clk     (clk),
        .reset_n (reset_n),
        .enable  (slave_on),
        .sif     (sif.detect)
    );

    assign ext_wr      = sif.write_evt;
    assign ext_rd      = sif.read_evt;
    assign cpu_wr_data = reg_write && hit(reg_addr, SBP_A_DATA_PINS);
    assign cpu_rd_data = reg_read && hit(reg_addr, SBP_A_DATA_PINS);

    always_comb begin
        nxt_st    = st_ff;
        flags_cur = st_ff.irq_flags;
        irq_req   = 1'b0;

        // Software register writes
        if (reg_write) begin
            case (reg_addr)
                SBP_A_CONTROL: begin
                    // Only overrun and mode select are writable
                    nxt_st.control = (st_ff.control & ~SBP_CTL_RW_MASK)
                                     | (reg_wdata & SBP_CTL_RW_MASK); // [R11] [R02]
                end
                SBP_A_DATA_PINS, SBP_A_DATA_LATCH: begin
                    nxt_st.data_latch = reg_wdata;
                end
                SBP_A_DATA_DIR: nxt_st.data_dir = reg_wdata;
                SBP_A_CTL_PINS, SBP_A_CTL_LATCH: begin
                    nxt_st.ctl_latch = reg_wdata;
                end
                SBP_A_CTL_DIR: nxt_st.ctl_dir = reg_wdata;
                SBP_A_IRQ_FLAGS: begin
                    // Write one to clear
                    nxt_st.irq_flags = st_ff.irq_flags & ~reg_wdata;
                end
                SBP_A_IRQ_ENABLES:  nxt_st.irq_en   = reg_wdata;
                SBP_A_IRQ_PRIORITY: nxt_st.irq_prio = reg_wdata;
                SBP_A_MODE:         nxt_st.mode     = reg_wdata;
                default: begin
                end
            endcase
        end

        // CPU side of the data latch in slave mode
        if (slave_on && cpu_wr_data) begin
            nxt_st.control[SBP_B_OUTPUT_FULL] = 1'b1; // [R10]
        end
        if (slave_on && cpu_rd_data) begin
            nxt_st.control[SBP_B_INPUT_FULL] = 1'b0; // [R09]
        end

        // External side; hardware set wins over software clear
        if (ext_wr) begin
            nxt_st.in_byte = data_sync; // [R08]
            if (st_ff.control[SBP_B_INPUT_FULL] && !cpu_rd_data) begin
                nxt_st.control[SBP_B_OVERRUN] = 1'b1; // [R11]
            end
            nxt_st.control[SBP_B_INPUT_FULL] = 1'b1; // [R09]
            nxt_st.irq_flags[SBP_B_IRQ]      = 1'b1; // [R14]
        end
        if (ext_rd) begin
            // A CPU write in the same cycle refills the latch, so its set wins
            if (!(slave_on && cpu_wr_data)) begin
                nxt_st.control[SBP_B_OUTPUT_FULL] = 1'b0; // [R10]
            end
            nxt_st.irq_flags[SBP_B_IRQ]       = 1'b1; // [R14]
        end
        nxt_st.control = nxt_st.control & SBP_CTL_RD_MASK; // [R12]

        // Read data, valid in the cycle after the strobe only
        nxt_st.rdata = SBP_ZERO;
        if (reg_read) begin
            case (reg_addr)
                SBP_A_CONTROL:      nxt_st.rdata = st_ff.control & SBP_CTL_RD_MASK; // [R12]
                SBP_A_DATA_PINS:    nxt_st.rdata = slave_on ? st_ff.in_byte : data_sync;
                SBP_A_DATA_LATCH:   nxt_st.rdata = st_ff.data_latch;
                SBP_A_DATA_DIR:     nxt_st.rdata = st_ff.data_dir;
                SBP_A_CTL_PINS:     nxt_st.rdata = ctl_pins_in;
                SBP_A_CTL_LATCH:    nxt_st.rdata = st_ff.ctl_latch;
                SBP_A_CTL_DIR:      nxt_st.rdata = st_ff.ctl_dir;
                SBP_A_IRQ_FLAGS:    nxt_st.rdata = st_ff.irq_flags;
                SBP_A_IRQ_ENABLES:  nxt_st.rdata = st_ff.irq_en;
                SBP_A_IRQ_PRIORITY: nxt_st.rdata = st_ff.irq_prio;
                SBP_A_MODE:         nxt_st.rdata = st_ff.mode;
                default:            nxt_st.rdata = SBP_ZERO;
            endcase
        end

        // Data pins: in slave mode driven only while the external master reads; otherwise per direction
        nxt_st.d_out = st_ff.data_latch;
        if (slave_on) begin
            nxt_st.d_oe_n = (!sif.cs_n && !sif.rd_n) ? SBP_ZERO : SBP_ONES; // [R08]
        end else begin
            nxt_st.d_oe_n = st_ff.data_dir;
        end

        // Strobe pins forced to inputs in slave mode; other bits follow direction
        nxt_st.c_out  = st_ff.ctl_latch;
        nxt_st.c_oe_n = st_ff.ctl_dir;
        if (slave_on) begin
            nxt_st.c_oe_n[SBP_P_CS:SBP_P_READ] = 3'h7; // [R03]
        end

        // Interrupt output, routed by priority
        flags_cur = nxt_st.irq_flags;
        irq_req   = flags_cur[SBP_B_IRQ] && st_ff.irq_en[SBP_B_IRQ]; // [R14]
        nxt_st.irq_h = irq_req && st_ff.irq_prio[SBP_B_IRQ];
        nxt_st.irq_l = irq_req && !st_ff.irq_prio[SBP_B_IRQ];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '{control: SBP_RST_CONTROL, data_latch: SBP_RST_LATCH,
                       data_dir: SBP_RST_DIR, in_byte: SBP_ZERO,
                       ctl_latch: SBP_RST_LATCH, ctl_dir: SBP_RST_DIR,
                       irq_flags: SBP_RST_IRQ_FLAGS, irq_en: SBP_RST_IRQ_EN,
                       irq_prio: SBP_RST_IRQ_PRIO, mode: SBP_ZERO,
                       rdata: SBP_ZERO, d_out: SBP_RST_LATCH, d_oe_n: SBP_ONES,
                       c_out: SBP_RST_LATCH, c_oe_n: SBP_ONES,
                       irq_h: 1'b0, irq_l: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata      = st_ff.rdata;
    assign data_pins_out  = st_ff.d_out;
    assign data_pins_oe_n = st_ff.d_oe_n;
    assign ctl_pins_out   = st_ff.c_out;
    assign ctl_pins_oe_n  = st_ff.c_oe_n;
    assign irq_high       = st_ff.irq_h;
    assign irq_low        = st_ff.irq_l;
endmodule // sbp_top

// ### sim/sbp_props.sv
// Assertion checker for the parallel slave port top
`timescale 1ns/1ps
module sbp_props
    import sbp_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic [SBP_AW-1:0] reg_addr,
    input wire logic [SBP_DW-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [SBP_DW-1:0] reg_rdata,
    input wire logic [SBP_DW-1:0] data_pins_oe_n,
    input wire logic [SBP_DW-1:0] ctl_pins_in,
    input wire logic [SBP_DW-1:0] ctl_pins_oe_n,
    input wire logic              irq_high,
    input wire logic              irq_low
);
    logic       sel_ff;
    logic       mcu_ff;
    logic [7:0] dir_ff;
    logic [3:0] rdl_ff;
    logic [3:0] idl_ff;
    logic       act;
    logic       rd_req;
    assign act    = sel_ff & mcu_ff;
    assign rd_req = ~ctl_pins_in[SBP_P_CS] & ~ctl_pins_in[SBP_P_READ];
    // Shadow of mode and direction; counters are raw so they lead the synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_ff <= 1'b0;
            mcu_ff <= 1'b0;
            dir_ff <= SBP_RST_DIR;
            rdl_ff <= 4'h0;
            idl_ff <= 4'h0;
        end else begin
            if (reg_write && reg_addr == SBP_A_CONTROL) begin
                sel_ff <= reg_wdata[SBP_B_SELECT];
            end
            if (reg_write && reg_addr == SBP_A_MODE) begin
                mcu_ff <= reg_wdata[SBP_B_INTERNAL_ONLY];
            end
            if (reg_write && reg_addr == SBP_A_DATA_DIR) begin
                dir_ff <= reg_wdata;
            end
            rdl_ff <= !rd_req ? 4'h0 : (rdl_ff == 4'hf ? rdl_ff : rdl_ff + 4'h1);
            idl_ff <= rd_req ? 4'h0 : (idl_ff == 4'hf ? idl_ff : idl_ff + 4'h1);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ctl_low_zero: assert property (
        $past(reg_read && reg_addr == SBP_A_CONTROL) |-> reg_rdata[3:0] == 4'h0)
        else $error("control low bits not zero");
    a_sel_readback: assert property (
        $past(reg_read && reg_addr == SBP_A_CONTROL) |-> reg_rdata[SBP_B_SELECT] == $past(sel_ff))
        else $error("mode select readback wrong");
    a_irq_excl: assert property (!(irq_high && irq_low))
        else $error("both interrupt levels high");
    a_irq_masked: assert property (
        $past(reg_write && reg_addr == SBP_A_IRQ_ENABLES && !reg_wdata[SBP_B_IRQ])
        |-> ##1 !(irq_high || irq_low))
        else $error("masked interrupt still requested");
    a_gp_dir_oe: assert property (
        !sel_ff && $past(!sel_ff, 3) && dir_ff == $past(dir_ff, 3) |-> data_pins_oe_n == dir_ff)
        else $error("general io enables differ from direction");
    a_slave_ctl_in: assert property (act && $past(act) |-> ctl_pins_oe_n[2:0] == 3'h7)
        else $error("strobe pins driven in slave mode");
    a_read_drive: assert property (
        act && $past(act, 8) && rdl_ff >= 4'h7 |-> data_pins_oe_n == SBP_ZERO)
        else $error("external read not driven");
    a_idle_release: assert property (
        act && $past(act, 8) && idl_ff >= 4'h7 |-> data_pins_oe_n == SBP_ONES)
        else $error("data bus driven while not read");
    c_irq_high: cover property (irq_high);
    c_irq_low: cover property (irq_low);
    c_ext_read: cover property (act && data_pins_oe_n == SBP_ZERO);
endmodule // sbp_props

bind sbp_top sbp_props chk_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .data_pins_oe_n(data_pins_oe_n), .ctl_pins_in(ctl_pins_in),
    .ctl_pins_oe_n(ctl_pins_oe_n), .irq_high(irq_high), .irq_low(irq_low));

// ### sim/sbp_ext_cpu.sv
// External byte-bus processor model driving the slave port strobes
`timescale 1ns/1ps
module sbp_ext_cpu
    import sbp_pkg::*;
(
    input  wire logic [SBP_DW-1:0] bus_in,
    input  wire logic              clk,
    output      logic [SBP_DW-1:0] bus_out,
    output      logic [2:0]        strobe_n
);
    initial begin
        bus_out  = 8'h00;
        strobe_n = 3'h7;
    end
    // Strobes low 9 cycles, high 8: above the 5 and 4 the synchroniser needs
    task automatic access(input logic is_rd, input logic [7:0] wd, output logic [7:0] rd);
        // On a read the bus stays released, so only the device can supply wd
        bus_out  <= is_rd ? ~wd : wd;
        strobe_n <= is_rd ? 3'h2 : 3'h1;
        repeat (9) @(posedge clk);
        rd = bus_in;
        strobe_n <= 3'h7;
        bus_out  <= ~wd; // Released bus must not keep showing the last byte
        repeat (8) @(posedge clk);
    endtask
endmodule // sbp_ext_cpu

// ### sim/parallel_slave_port_tb.sv
// Self-checking bench for the parallel slave port
`timescale 1ns/1ps
module parallel_slave_port_tb;
    import sbp_pkg::*;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic [SBP_AW-1:0] reg_addr = 4'h0;
    logic [SBP_DW-1:0] reg_wdata = 8'h00;
    logic              reg_write = 1'b0;
    logic              reg_read = 1'b0;
    logic [SBP_DW-1:0] reg_rdata, d_out, d_oe_n, d_in, c_out, c_oe_n, ext_bus;
    logic [2:0]        strobe_n;
    logic              irq_high, irq_low;
    logic [3:0]        rst_a [8] = '{4'h0, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hf};
    logic [7:0]        rst_v [8] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    int                miscompares = 0;
    int                tests_run = 0;
    always #10 clk = ~clk;
    // Open bus: the DUT wins on bits it enables, else whatever the model drives on bus_out
    assign d_in = (~d_oe_n & d_out) | (d_oe_n & ext_bus);
    sbp_top dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .data_pins_in(d_in), .data_pins_out(d_out), .data_pins_oe_n(d_oe_n),
        .ctl_pins_in({5'h1f, strobe_n}), .ctl_pins_out(c_out), .ctl_pins_oe_n(c_oe_n),
        .irq_high(irq_high), .irq_low(irq_low));
    sbp_ext_cpu ext_u (.bus_in(d_in), .clk(clk), .bus_out(ext_bus), .strobe_n(strobe_n));
    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk8(reg_rdata, exp);
    endtask
    // External access; a read compares the byte seen on the bus
    task automatic ext(input logic is_rd, input logic [7:0] d);
        logic [7:0] got;
        @(posedge clk);
        ext_u.access(is_rd, d, got);
        if (is_rd) begin
            chk8(got, d);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rdc(rst_a[i], rst_v[i]);
        end
        wr(SBP_A_CONTROL, 8'hdf);
        rdc(SBP_A_CONTROL, 8'h10);
        rdc(SBP_A_CTL_PINS, 8'hff);
        wr(SBP_A_CTL_DIR, 8'hff);
        wr(SBP_A_IRQ_ENABLES, 8'h80);
        ext(1'b0, 8'h11);
        rdc(SBP_A_CONTROL, 8'h10);
        rdc(SBP_A_IRQ_FLAGS, 8'h00);
        wr(SBP_A_MODE, 8'h01);
        ext(1'b0, 8'ha5);
        rdc(SBP_A_CONTROL, 8'h90);
        chk1(irq_high, 1'b1);
        chk1(irq_low, 1'b0);
        rdc(SBP_A_IRQ_FLAGS, 8'h80);
        rdc(SBP_A_DATA_PINS, 8'ha5);
        rdc(SBP_A_CONTROL, 8'h10);
        ext(1'b0, 8'h3c);
        rdc(SBP_A_CONTROL, 8'h90);
        ext(1'b0, 8'hc3);
        rdc(SBP_A_CONTROL, 8'hb0);
        wr(SBP_A_CONTROL, 8'h10);
        rdc(SBP_A_CONTROL, 8'h90);
        rdc(SBP_A_DATA_PINS, 8'hc3);
        wr(SBP_A_IRQ_FLAGS, 8'h80);
        rdc(SBP_A_IRQ_FLAGS, 8'h00);
        chk1(irq_high, 1'b0);
        wr(SBP_A_IRQ_PRIORITY, 8'h00);
        wr(SBP_A_DATA_PINS, 8'h5a);
        rdc(SBP_A_CONTROL, 8'h50);
        rdc(SBP_A_DATA_LATCH, 8'h5a);
        ext(1'b1, 8'h5a);
        rdc(SBP_A_CONTROL, 8'h10);
        chk1(irq_low, 1'b1);
        chk1(irq_high, 1'b0);
        wr(SBP_A_IRQ_ENABLES, 8'h00);
        rdc(SBP_A_IRQ_ENABLES, 8'h00);
        chk1(irq_low, 1'b0);
        wr(SBP_A_CONTROL, 8'h00);
        wr(SBP_A_DATA_DIR, 8'h0f);
        rdc(SBP_A_DATA_DIR, 8'h0f);
        chk8(d_oe_n, 8'h0f);
        ext(1'b0, 8'h77);
        rdc(SBP_A_CONTROL, 8'h00);
        wr(SBP_A_CTL_LATCH, 8'h3c);
        wr(SBP_A_CTL_DIR, 8'h00);
        rdc(SBP_A_CTL_DIR, 8'h00);
        chk8(c_oe_n, 8'h00);
        chk8(c_out, 8'h3c);
        conclude();
    end
endmodule // parallel_slave_port_tb
